// ===== rsw_map.svh
// Operation
// - In reset halt core, load registers, block interrupts; restart at 0x0000.
// - Reset leaves data memory intact; stack pointer still reinitialised.
// - Reset loads port latches with 0xff; weak pull-ups stay enabled.
// - Supply or software power-on reset drives reset pin low until timeout.
// - Hold reset below supply threshold, then pin low for 100 ms.
// - After reset the system clock is internal oscillator at 2 MHz.
// - Every reset exit enables watchdog with interval field 111b.
// - Power-on reset sets power_on_flag; any other reset clears it.
// - Software writing 1 to power_on_flag forces a full power-on reset.
// - Supply drop drives pin low, resets; recovery exits like power-on.
// - Low reset pin resets; exit 12 cycles after release, set pin flag.
// - Enabled clock-loss detection resets; flag reads 1 after, pin untouched.
// - Enabled comparator trip resets even without clock; flag reads 1 after.
// - Enabled low convert_start_input holds reset; flag reads 1 after.
// - 21-bit watchdog overflow forces reset without touching reset pin.
// - Writing 0xa5 enables and restarts the watchdog.
// - Disable only by 0xde then 0xad within 4 clocks.
// - Writing 0xff locks out disable until reset; no enable or restart.
// - Timeout is 4^(3+interval) clocks; interval written when bit 7 is 0.
// - Watchdog control read bit 4 shows watchdog active.
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH
`define RSW_CLK_MHZ 250
`define RSW_POR_TIME_MS 100
`define RSW_PIN_STRETCH 12
`define RSW_KEY_WIN 4
`define RSW_OFS_OSC 8'hb2
`define RSW_OFS_SRC 8'hef
`define RSW_OFS_WDT 8'hff
`define RSW_KEY_KICK 8'ha5
`define RSW_KEY_DIS1 8'hde
`define RSW_KEY_DIS2 8'had
`define RSW_KEY_LOCK 8'hff
`define RSW_WDT_INT_RST 3'h7
`define RSW_OSC_RST 8'h04
`define RSW_PORT_RST 8'hff
`define RSW_PC_RST 16'h0000
`define RSW_BIT_PIN 0
`define RSW_BIT_POR 1
`define RSW_BIT_MCD 2
`define RSW_BIT_WDT 3
`define RSW_BIT_CMP 5
`define RSW_BIT_CNV 6
`define RSW_BIT_WACT 4
`define RSW_BIT_WLOCK 7
`define RSW_BIT_MCDEN 7
`define RSW_BIT_IFRDY 4
`define RSW_BIT_CLKSL 3
`endif

// ===== rsw_pkg.sv
package rsw_pkg;
  // Reset sequencer states, one-hot
  typedef enum logic [3:0] {
    RSW_ST_POR = 4'b0001,
    RSW_ST_HOLD = 4'b0010,
    RSW_ST_STRETCH = 4'b0100,
    RSW_ST_RUN = 4'b1000
  } rsw_state_t;
  // Cause of the current or prior reset
  typedef struct packed {
    logic cnv;
    logic cmp;
    logic wdt;
    logic mcd;
    logic por;
    logic pin;
  } rsw_cause_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsw_req_t;
endpackage : rsw_pkg

// ===== rsw_reset_ctrl.sv
`timescale 1ns/1ps
`include "rsw_map.svh"
module rsw_reset_ctrl #(
  parameter int POR_TIME_MS = `RSW_POR_TIME_MS,
  parameter int POR_CYC = POR_TIME_MS * `RSW_CLK_MHZ * 1000,
  parameter int WDT_W = 21
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire rsw_pkg::rsw_req_t REQ,
  output logic [7:0] RDATA,
  input wire logic SUPPLY_OK,
  input wire logic RST_PIN_IN,
  output logic RST_PIN_OUT,
  output logic RST_PIN_OE_N,
  input wire logic CNV_START_N,
  input wire logic CMP_PLUS_BELOW,
  input wire logic CLK_LOST,
  output logic CORE_RST,
  output logic [15:0] PC_INIT,
  output logic [7:0] PORT_INIT,
  output logic PULLUP_EN,
  output logic RAM_HOLD,
  output logic CLK_SEL_EXT,
  output logic [1:0] OSC_FREQ,
  output logic OSC_EN,
  output logic WDT_ACTIVE
);
  import rsw_pkg::*;

  localparam int STRETCH = `RSW_PIN_STRETCH;
  localparam int POR_LAST = (POR_CYC < 1) ? 0 : POR_CYC - 1;

  rsw_state_t state_r;
  rsw_state_t state_nxt;
  rsw_cause_t cause_r;
  rsw_cause_t flags_r;
  logic [31:0] cnt_r;
  logic cmp_en_r;
  logic cnv_en_r;
  logic mcd_en_r;
  logic clksl_r;
  logic iosc_en_r;
  logic [1:0] ifcn_r;
  logic sw_por_r;
  logic wdt_en_r;
  logic wdt_lock_r;
  logic [2:0] wdt_int_r;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [2:0] win_r;
  logic wdt_ovf;
  logic in_rst;
  logic bus_ok;
  logic wr_wdt;
  logic wr_src;
  logic wr_osc;
  logic [7:0] rdata_r;
  rsw_cause_t src_now;
  logic [4:0] stretch_cyc_r;

  // Timeout length 4^(3+n) clock periods
  function automatic logic [WDT_W-1:0] wdt_limit(input logic [2:0] n);
    logic [WDT_W:0] v;
    v = '0;
    v[6 + 2 * n] = 1'b1;
    wdt_limit = v[WDT_W-1:0] - 1'b1;
  endfunction : wdt_limit

  // Register write decode, shared by every register
  function automatic logic hit(input rsw_req_t q, input logic [7:0] a);
    hit = q.wr && (q.addr == a);
  endfunction : hit

  // Core reset holds while not running; comparator path skips the clock
  assign in_rst = (state_r != RSW_ST_RUN);
  assign CORE_RST = in_rst | (cmp_en_r & CMP_PLUS_BELOW);
  assign bus_ok = !in_rst;
  assign wr_wdt = bus_ok && hit(REQ, `RSW_OFS_WDT);
  assign wr_src = bus_ok && hit(REQ, `RSW_OFS_SRC);
  assign wr_osc = bus_ok && hit(REQ, `RSW_OFS_OSC);

  // Fixed reset values plus live oscillator and watchdog state presented to the core
  assign PC_INIT = `RSW_PC_RST;
  assign PORT_INIT = `RSW_PORT_RST;
  assign PULLUP_EN = 1'b1;
  assign RAM_HOLD = 1'b1;
  assign CLK_SEL_EXT = clksl_r;
  assign OSC_FREQ = ifcn_r;
  assign OSC_EN = iosc_en_r;
  assign WDT_ACTIVE = wdt_en_r;

  // Reset pin is open drain; only power-on resets, supply or software, pull it low
  assign RST_PIN_OUT = 1'b0;
  assign RST_PIN_OE_N = !(state_r == RSW_ST_POR);

  // Live reset sources seen while running
  always_comb begin
    src_now = '0;
    src_now.pin = !RST_PIN_IN;
    src_now.cnv = cnv_en_r && !CNV_START_N;
    src_now.cmp = cmp_en_r && CMP_PLUS_BELOW;
    src_now.mcd = mcd_en_r && CLK_LOST;
    src_now.wdt = wdt_ovf;
    src_now.por = sw_por_r;
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSW_ST_POR: begin
        if (SUPPLY_OK && cnt_r == POR_LAST) begin
          state_nxt = RSW_ST_RUN;
        end
      end
      RSW_ST_HOLD: begin
        if (!(src_now.pin || (cause_r.cnv && !CNV_START_N)
            || (cause_r.cmp && CMP_PLUS_BELOW)
            || (cause_r.mcd && CLK_LOST))) begin
          state_nxt = RSW_ST_STRETCH;
        end
      end
      RSW_ST_STRETCH: begin
        if (src_now.pin) begin
          state_nxt = RSW_ST_HOLD;
        end else if (cnt_r == 32'(STRETCH - 1)) begin
          state_nxt = RSW_ST_RUN;
        end
      end
      RSW_ST_RUN: begin
        if (src_now.por) begin
          state_nxt = RSW_ST_POR;
        end else if (|src_now) begin
          state_nxt = RSW_ST_HOLD;
        end
      end
      default: state_nxt = RSW_ST_POR;
    endcase
    if (!SUPPLY_OK) begin
      state_nxt = RSW_ST_POR;
    end
  end

  // Sequencer state register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= RSW_ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Timeout counter, restarted on each state change
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r || !SUPPLY_OK) begin
      cnt_r <= '0;
    end else if (state_r != RSW_ST_RUN) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Cause latched on reset entry
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cause_r <= '0;
    end else if (state_r == RSW_ST_RUN && state_nxt == RSW_ST_HOLD) begin
      cause_r <= src_now;
    end else if (state_nxt == RSW_ST_POR) begin
      cause_r <= '0;
    end
  end

  // Reset flags published on exit
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      flags_r <= '0;
    end else if (in_rst && state_nxt == RSW_ST_RUN) begin
      if (state_r == RSW_ST_POR) begin
        flags_r <= '0;
        flags_r.por <= 1'b1;
      end else begin
        flags_r <= cause_r;
        flags_r.pin <= cause_r.pin || src_now.pin;
        flags_r.por <= 1'b0;
      end
    end
  end

  // Reset source enables; cleared by any reset
  always_ff @(posedge CLK) begin
    if (SYS_RST || in_rst) begin
      cmp_en_r <= 1'b0;
      cnv_en_r <= 1'b0;
      sw_por_r <= 1'b0;
    end else if (wr_src) begin
      cmp_en_r <= REQ.wdata[`RSW_BIT_CMP];
      cnv_en_r <= REQ.wdata[`RSW_BIT_CNV];
      sw_por_r <= REQ.wdata[`RSW_BIT_POR];
    end
  end

  // Oscillator control, defaults to internal 2 MHz
  always_ff @(posedge CLK) begin
    if (SYS_RST || in_rst) begin
      mcd_en_r <= 1'(`RSW_OSC_RST >> `RSW_BIT_MCDEN);
      clksl_r <= 1'b0;
      iosc_en_r <= 1'b1;
      ifcn_r <= 2'h0;
    end else if (wr_osc) begin
      mcd_en_r <= REQ.wdata[`RSW_BIT_MCDEN];
      clksl_r <= REQ.wdata[`RSW_BIT_CLKSL];
      iosc_en_r <= REQ.wdata[2];
      ifcn_r <= REQ.wdata[1:0];
    end
  end

  // Watchdog enable and disable lockout
  always_ff @(posedge CLK) begin
    if (SYS_RST || in_rst) begin
      wdt_en_r <= 1'b1;
      wdt_lock_r <= 1'b0;
    end else if (wr_wdt) begin
      if (REQ.wdata == `RSW_KEY_KICK) begin
        wdt_en_r <= 1'b1;
      end else if (REQ.wdata == `RSW_KEY_LOCK) begin
        wdt_lock_r <= 1'b1;
      end else if (REQ.wdata == `RSW_KEY_DIS2 && win_r != 3'h0
                   && !wdt_lock_r) begin
        wdt_en_r <= 1'b0;
      end
    end
  end

  // Disable window opened by the first key byte
  always_ff @(posedge CLK) begin
    if (SYS_RST || in_rst) begin
      win_r <= 3'h0;
    end else if (wr_wdt) begin
      if (REQ.wdata == `RSW_KEY_DIS1) begin
        win_r <= 3'(`RSW_KEY_WIN);
      end else begin
        win_r <= 3'h0;
      end
    end else if (win_r != 3'h0) begin
      win_r <= win_r - 3'h1;
    end
  end

  // Watchdog interval field
  always_ff @(posedge CLK) begin
    if (SYS_RST || in_rst) begin
      wdt_int_r <= `RSW_WDT_INT_RST;
    end else if (wr_wdt && !REQ.wdata[`RSW_BIT_WLOCK]) begin
      wdt_int_r <= REQ.wdata[2:0];
    end
  end

  // Watchdog timer and overflow
  assign wdt_ovf = wdt_en_r && (wdt_cnt_r == wdt_limit(wdt_int_r));
  always_ff @(posedge CLK) begin
    if (SYS_RST || in_rst) begin
      wdt_cnt_r <= '0;
    end else if (wr_wdt && REQ.wdata == `RSW_KEY_KICK) begin
      wdt_cnt_r <= '0;
    end else if (wdt_en_r && !wdt_ovf) begin
      wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_r <= 8'h00;
    end else if (REQ.rd) begin
      case (REQ.addr)
        `RSW_OFS_WDT:
          rdata_r <= {3'h0, wdt_en_r, 1'b0, wdt_int_r};
        `RSW_OFS_SRC:
          rdata_r <= {1'b0, flags_r.cnv, flags_r.cmp, 1'b0,
                      flags_r.wdt, flags_r.mcd, flags_r.por, flags_r.pin};
        `RSW_OFS_OSC:
          rdata_r <= {mcd_en_r, 2'h0, 1'b1, clksl_r, iosc_en_r, ifcn_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign RDATA = rdata_r;

  // Cycles spent in the current stretch, counted apart from cnt_r
  always_ff @(posedge CLK) begin
    if (SYS_RST || state_r != RSW_ST_STRETCH) begin
      stretch_cyc_r <= 5'h0;
    end else begin
      stretch_cyc_r <= stretch_cyc_r + 5'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_dis1;
    wr_wdt && REQ.wdata == `RSW_KEY_DIS1 && !wdt_lock_r;
  endsequence
  sequence s_dis2;
    wr_wdt && REQ.wdata == `RSW_KEY_DIS2;
  endsequence

  a_por_pin_low: assert property (
    state_r == RSW_ST_POR |-> !RST_PIN_OE_N && !RST_PIN_OUT)
    else $error("reset pin not driven in power-on reset");

  a_pin_untouched: assert property (
    state_r != RSW_ST_POR |-> RST_PIN_OE_N)
    else $error("reset pin driven by a non-supply reset");

  a_stretch_hold: assert property (
    $past(state_r == RSW_ST_STRETCH) && state_r == RSW_ST_RUN
      |-> stretch_cyc_r == 5'(STRETCH))
    else $error("pin reset stretch not 12 cycles");

  a_por_flag_set: assert property (
    state_r == RSW_ST_POR && state_nxt == RSW_ST_RUN
      |=> flags_r.por && !flags_r.pin)
    else $error("power-on flag wrong after power-on exit");

  a_other_clears: assert property (
    state_r == RSW_ST_STRETCH && state_nxt == RSW_ST_RUN |=> !flags_r.por)
    else $error("power-on flag kept after other reset");

  a_wdt_on_exit: assert property (
    $fell(in_rst) |-> wdt_en_r && wdt_int_r == 3'h7 && wdt_cnt_r == '0)
    else $error("watchdog not armed at reset exit");

  a_kick_restart: assert property (
    wr_wdt && REQ.wdata == `RSW_KEY_KICK && !wdt_ovf
      |=> wdt_en_r && wdt_cnt_r == '0)
    else $error("kick did not restart watchdog");

  a_dis_seq: assert property (
    s_dis1 ##1 (!wr_wdt) [*3] ##1 s_dis2 |=> !wdt_en_r)
    else $error("disable within window ignored");

  a_dis_late: assert property (
    s_dis1 ##1 (!wr_wdt) [*4] ##1 (s_dis2 and wdt_en_r) |=> wdt_en_r)
    else $error("late disable key accepted");

  a_lock_blocks: assert property (
    (s_dis2 and (wdt_lock_r && wdt_en_r)) |=> wdt_en_r)
    else $error("disable accepted while locked");

  a_lock_noop: assert property (
    wr_wdt && REQ.wdata == `RSW_KEY_LOCK && !wdt_ovf
      |=> wdt_lock_r && (wdt_en_r == $past(wdt_en_r)
          && wdt_cnt_r == $past(wdt_cnt_r) + 1'b1 || !$past(wdt_en_r)))
    else $error("lock write touched the timer");

  a_ovf_resets: assert property (
    wdt_ovf && !in_rst |=> in_rst ##1 cause_r.wdt || !SUPPLY_OK)
    else $error("overflow did not reset");

  a_ovf_at_limit: assert property (
    wdt_en_r && wdt_int_r == 3'h0 && wdt_cnt_r == 21'd62 && !in_rst
      && !wr_wdt |=> wdt_ovf)
    else $error("timeout not 64 cycles at interval 0");

  a_osc_default: assert property (
    $fell(in_rst) |-> !clksl_r && ifcn_r == 2'h0)
    else $error("clock not internal 2 MHz after reset");

  a_cmp_async: assert property (
    cmp_en_r && CMP_PLUS_BELOW |-> CORE_RST)
    else $error("comparator trip did not reset");

endmodule : rsw_reset_ctrl

// ===== rsw_ext_model.sv
`timescale 1ns/1ps
module rsw_ext_model #(
  parameter int SETTLE_CYC = 5000
) (
  input wire logic clk,
  input wire logic pin_oe_n,
  input wire logic pin_out,
  input wire logic button_n,
  input wire logic supply_on,
  input wire logic cmp_on,
  input wire logic cmp_raw,
  output logic pin_level,
  output logic supply_ok,
  output logic cmp_out
);
  int settle_cnt;
  // Reset wire with pull-up, low when either side pulls
  assign pin_level = ~((~pin_oe_n & ~pin_out) | ~button_n);
  assign supply_ok = supply_on;
  // Comparator warm-up time
  always_ff @(posedge clk) begin
    if (!cmp_on) settle_cnt <= 0;
    else if (settle_cnt < SETTLE_CYC) settle_cnt <= settle_cnt + 1;
  end
  // Output chatters until warmed up
  assign cmp_out = !cmp_on ? 1'h0 :
    (settle_cnt < SETTLE_CYC) ? settle_cnt[0] : cmp_raw;
endmodule : rsw_ext_model

// ===== test_reset_source_and_watchdog.sv
`timescale 1ns/1ps
module test_reset_source_and_watchdog;
  import rsw_pkg::*;
  logic clk, sys_rst, button_n, supply_on, cmp_on, cmp_raw, cnv_n;
  logic clk_lost, pin_lvl, sup_ok, cmp_out, oe_seen;
  rsw_req_t req;
  logic [7:0] rdata, port_init;
  logic [15:0] pc_init;
  logic pin_out, pin_oe_n, core_rst, pullup_en, ram_hold;
  logic clk_sel_ext, osc_en, wdt_active;
  logic [1:0] osc_freq;
  int failures, total_checks;
  rsw_reset_ctrl #(.POR_CYC(20)) dut (
    .CLK(clk), .SYS_RST(sys_rst), .REQ(req), .RDATA(rdata),
    .SUPPLY_OK(sup_ok), .RST_PIN_IN(pin_lvl), .RST_PIN_OUT(pin_out),
    .RST_PIN_OE_N(pin_oe_n), .CNV_START_N(cnv_n),
    .CMP_PLUS_BELOW(cmp_out), .CLK_LOST(clk_lost), .CORE_RST(core_rst),
    .PC_INIT(pc_init), .PORT_INIT(port_init), .PULLUP_EN(pullup_en),
    .RAM_HOLD(ram_hold), .CLK_SEL_EXT(clk_sel_ext), .OSC_FREQ(osc_freq),
    .OSC_EN(osc_en), .WDT_ACTIVE(wdt_active)
  );
  rsw_ext_model ext (
    .clk(clk), .pin_oe_n(pin_oe_n), .pin_out(pin_out),
    .button_n(button_n), .supply_on(supply_on), .cmp_on(cmp_on),
    .cmp_raw(cmp_raw), .pin_level(pin_lvl), .supply_ok(sup_ok),
    .cmp_out(cmp_out)
  );
  // Clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Notes any pull of the reset pin by the controller
  always @(posedge clk) if (pin_oe_n === 1'h0) oe_seen = 1'h1;
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task wr(input logic [7:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'h1;
    @(posedge clk);
    req.wr <= 1'h0;
    @(posedge clk);
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge clk);
    req.rd <= 1'h0;
    #1 d = rdata;
  endtask : rd
  // Two watchdog writes with a gap of idle cycles
  task pair(input logic [7:0] d1, d2, input int gap);
    req.addr <= 8'hff;
    req.wdata <= d1;
    req.wr <= 1'h1;
    @(posedge clk);
    if (gap > 0) begin
      req.wr <= 1'h0;
      repeat (gap) @(posedge clk);
    end
    req.wdata <= d2;
    req.wr <= 1'h1;
    @(posedge clk);
    req.wr <= 1'h0;
    @(posedge clk);
  endtask : pair
  task wait_rst(input logic lvl, output int n);
    n = 0;
    while (core_rst !== lvl && n < 500) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_rst
  function automatic logic [7:0] wctl(input logic act, input logic [2:0] iv);
    return {3'h0, act, 1'h0, iv};
  endfunction : wctl
  // State after any reset
  task settle(input logic [7:0] flags, input logic oe);
    int n;
    logic [7:0] d;
    wait_rst(1'h0, n);
    chk("leave reset", 1'h1, n < 500);
    @(posedge clk);
    rd(8'hef, d);
    chk("cause flags", flags, d);
    rd(8'hff, d);
    chk("wdt ctrl", wctl(1'h1, 3'h7), d);
    chk("pc", 16'h0000, pc_init);
    chk("port latch", 8'hff, port_init);
    chk("pullup", 1'h1, pullup_en);
    chk("ram kept", 1'h1, ram_hold);
    chk("osc", 4'h1, {clk_sel_ext, osc_freq, osc_en});
    chk("wdt on", 1'h1, wdt_active);
    chk("pin pulled", oe, oe_seen);
    oe_seen = 1'h0;
  endtask : settle
  initial begin
    int n;
    int i;
    logic [7:0] d, v;
    failures = 0;
    total_checks = 0;
    req = '0;
    {sys_rst, button_n, supply_on, cnv_n} = 4'hf;
    {cmp_on, cmp_raw, clk_lost, oe_seen} = 4'h0;
    void'($urandom(20731));
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    settle(8'h02, 1'h1);
    rd(8'h55, d);
    chk("unmapped", 8'h00, d);
    // External pin reset and stretch
    button_n <= 1'h0;
    repeat (3) @(posedge clk);
    button_n <= 1'h1;
    wait_rst(1'h0, n);
    chk("stretch", 1'h1, n >= 13 && n <= 15);
    settle(8'h01, 1'h0);
    // Second key on the last cycle of the window
    pair(8'hde, 8'had, 3);
    rd(8'hff, d);
    chk("disabled", wctl(1'h0, 3'h7), d);
    // Random intervals, corners first and last
    for (i = 0; i < 8; i++) begin
      v = {1'h0, 7'($urandom)};
      if (i == 0) v = 8'h7f;
      if (i == 7) v = 8'h00;
      wr(8'hff, v);
      rd(8'hff, d);
      chk("interval", wctl(1'h0, v[2:0]), d);
    end
    wr(8'hff, 8'ha5);
    pair(8'hde, 8'ha5, 0);
    wr(8'hff, 8'had);
    rd(8'hff, d);
    chk("cancelled", wctl(1'h1, 3'h0), d);
    pair(8'hde, 8'had, 4);
    rd(8'hff, d);
    chk("late key", wctl(1'h1, 3'h0), d);
    pair(8'hde, 8'had, 0);
    wr(8'hff, 8'hff);
    rd(8'hff, d);
    chk("lock no enable", wctl(1'h0, 3'h0), d);
    wr(8'hff, 8'ha5);
    pair(8'hde, 8'had, 0);
    rd(8'hff, d);
    chk("locked", wctl(1'h1, 3'h0), d);
    wr(8'hff, 8'ha5);
    wait_rst(1'h1, n);
    chk("wdt timeout", 1'h1, n >= 60 && n <= 68);
    settle(8'h08, 1'h0);
    wr(8'hef, 8'h02);
    wait_rst(1'h1, n);
    settle(8'h02, 1'h1);
    wr(8'hb2, 8'h0b);
    chk("osc set", 4'he, {clk_sel_ext, osc_freq, osc_en});
    supply_on <= 1'h0;
    repeat (40) @(posedge clk);
    chk("supply low", 2'h1, {pin_oe_n, core_rst});
    supply_on <= 1'h1;
    settle(8'h02, 1'h1);
    clk_lost <= 1'h1;
    repeat (5) @(posedge clk);
    #1 chk("mcd off", 1'h0, core_rst);
    wr(8'hb2, 8'h84);
    wait_rst(1'h1, n);
    clk_lost <= 1'h0;
    settle(8'h04, 1'h0);
    // Convert input already routed and idle high
    wr(8'hef, 8'h40);
    cnv_n <= 1'h0;
    repeat (30) @(posedge clk);
    #1 chk("cnv hold", 1'h1, core_rst);
    cnv_n <= 1'h1;
    settle(8'h40, 1'h0);
    cmp_on <= 1'h1;
    repeat (5010) @(posedge clk);
    wr(8'hef, 8'h20);
    cmp_raw <= 1'h1;
    #1 chk("cmp trip", 1'h1, core_rst);
    repeat (3) @(posedge clk);
    cmp_raw <= 1'h0;
    settle(8'h20, 1'h0);
    tally_and_finish();
  end
  // Watchdog on the whole run
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule : test_reset_source_and_watchdog
